// ---- design/opmode_pkg.sv ----
// constants, encodings and register map of the operating-mode sequencer
package opmode_pkg;

	// clock and derived time bases
	localparam longint CLK_HZ            = 100_000_000;
	localparam longint BLINK_HZ          = 2;
	localparam logic [31:0] BLINK_HALF_CYCLES = 32'(CLK_HZ / (2 * BLINK_HZ));
	localparam longint IO_READY_MS       = 60000;
	localparam logic [32:0] IO_READY_CYCLES = 33'(IO_READY_MS * CLK_HZ / 1000);
	// lamp test length in half blink periods (eight halves, 2 s)
	localparam logic [3:0] LAMP_TEST_HALVES = 4'h8;

	// register offsets (byte addresses)
	localparam logic [4:0] OFS_CMD      = 5'h00;
	localparam logic [4:0] OFS_CFG      = 5'h04;
	localparam logic [4:0] OFS_STATUS   = 5'h08;
	localparam logic [4:0] OFS_IRQ_STAT = 5'h0C;
	localparam logic [4:0] OFS_IRQ_MASK = 5'h10;

	// command bits
	localparam int CMD_PG_RUN    = 0;
	localparam int CMD_DISP_RUN  = 1;
	localparam int CMD_PG_STOP   = 2;
	localparam int CMD_DISP_STOP = 3;

	// configuration layout and reset value
	localparam int CFG_COMMISSIONED       = 2;
	localparam logic [2:0] CFG_RESET      = 3'h0;
	localparam logic [1:0] START_NO_RESTART = 2'h0;
	localparam logic [1:0] START_WARM_RUN   = 2'h1;
	localparam logic [1:0] START_RESTORE    = 2'h2;

	// interrupt event bits
	localparam int IRQ_W          = 5;
	localparam int EV_STOP        = 0;
	localparam int EV_RUN         = 1;
	localparam int EV_ABORT       = 2;
	localparam int EV_CARD        = 3;
	localparam int EV_IO_TIMEOUT  = 4;
	localparam logic [4:0] IRQ_RESET = 5'h00;

	// reported operating mode
	localparam logic [1:0] MODE_STOP    = 2'h0;
	localparam logic [1:0] MODE_STARTUP = 2'h1;
	localparam logic [1:0] MODE_RUN     = 2'h2;
	localparam logic [1:0] MODE_INIT    = 2'h3;

	typedef enum logic [2:0]
	{
		ST_LAMP_TEST = 3'h0,
		ST_SYS_INIT  = 3'h1,
		ST_STOP      = 3'h2,
		ST_STARTUP   = 3'h3,
		ST_RUN       = 3'h4,
		ST_CARD_EVAL = 3'h5
	} mode_state_e;

endpackage

// ---- design/blink_if.sv ----
// blink timebase carried from the divider to the sequencer
`timescale 1ns/10ps
interface blink_if;
	logic tick;
	logic phase;
	modport src (output tick, output phase);
	modport snk (input tick, input phase);
endinterface // blink_if

// ---- design/sync2.sv ----
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module sync2
#(
	parameter int WIDTH = 3
)
(
	input  wire logic             core_clk,
	input  wire logic             resetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	// first stage is read only by the second stage
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta_ff  <= '0;
			sync_out <= '0;
		end
		else
		begin
			meta_ff  <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule // sync2

// ---- design/blink_div.sv ----
// lamp blink divider: half-period tick and phase
`timescale 1ns/10ps
module blink_div
#(
	parameter logic [31:0] HALF = opmode_pkg::BLINK_HALF_CYCLES
)
(
	input  wire logic core_clk,
	input  wire logic resetn,
	blink_if.src      blink
);
	logic [31:0] cnt_ff;
	logic        tick_ff;
	logic        phase_ff;

	assign blink.tick  = tick_ff;
	assign blink.phase = phase_ff;

	// divided system clock, phase toggles every half period
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_ff   <= 32'h0;
			tick_ff  <= 1'b0;
			phase_ff <= 1'b0;
		end
		else
		begin
			tick_ff <= (cnt_ff == HALF - 32'h1);
			if (cnt_ff == HALF - 32'h1)
			begin
				cnt_ff   <= 32'h0;
				phase_ff <= ~phase_ff;
			end
			else
			begin
				cnt_ff <= cnt_ff + 32'h1;
			end
		end
	end
endmodule // blink_div

// ---- design/opmode_seq.sv ----
// operating-mode sequencer: modes, lamps, card handling, register port
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module opmode_seq
#(
	parameter logic [31:0] BLINK_HALF = opmode_pkg::BLINK_HALF_CYCLES,
	parameter logic [32:0] IO_READY   = opmode_pkg::IO_READY_CYCLES
)
(
	input  wire logic        core_clk,
	input  wire logic        resetn,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        selector_run,
	input  wire logic        card_present,
	input  wire logic        card_formatted,
	input  wire logic        card_eval_done,
	input  wire logic        hw_config_loaded,
	input  wire logic        blocks_consistent,
	input  wire logic        prev_mode_run,
	input  wire logic        startup_error,
	input  wire logic        startup_stop_cmd,
	input  wire logic        tags_initialized,
	input  wire logic        startup_blocks_done,
	input  wire logic        io_ready,
	input  wire logic        run_error,
	input  wire logic        user_stop_cmd,
	output logic             mode_lamp_yellow,
	output logic             mode_lamp_green,
	output logic             fault_lamp,
	output logic             service_lamp,
	output logic             mem_reset,
	output logic             clear_nonretentive,
	output logic             network_port_enable,
	output logic      [1:0]  op_mode,
	output logic             irq
);
	blink_if blink ();

	opmode_pkg::mode_state_e state_ff;
	opmode_pkg::mode_state_e nxt_state;
	logic [2:0]  pin_s;
	logic        sel_prev_ff;
	logic        card_prev_ff;
	logic        card_ok_ff;
	logic [3:0]  cmd_ff;
	logic [2:0]  cfg_ff;
	logic [3:0]  half_cnt_ff;
	logic [32:0] io_cnt_ff;
	logic [opmode_pkg::IRQ_W-1:0] irq_stat_ff;
	logic [opmode_pkg::IRQ_W-1:0] irq_mask_ff;
	logic [opmode_pkg::IRQ_W-1:0] nxt_irq_stat;
	logic [opmode_pkg::IRQ_W-1:0] event_v;
	logic        sel_up;
	logic        card_take;
	logic        start_ok;
	logic        auto_run;
	logic        run_req;
	logic        io_timeout;
	logic        in_init;

	// true when the address selects the given register, with or without a strobe
	function automatic logic hit(input logic [4:0] addr, input logic [4:0] ofs);
		hit = (addr == ofs);
	endfunction

	blink_div #(.HALF(BLINK_HALF)) u_blink
	(
		.core_clk (core_clk),
		.resetn   (resetn),
		.blink    (blink)
	);

	sync2 #(.WIDTH(3)) u_sync
	(
		.core_clk (core_clk),
		.resetn   (resetn),
		.async_in ({card_formatted, card_present, selector_run}),
		.sync_out (pin_s)
	);

	// edge trackers and card acceptance
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			sel_prev_ff  <= 1'b0;
			card_prev_ff <= 1'b0;
			card_ok_ff   <= 1'b0;
		end
		else
		begin
			sel_prev_ff  <= pin_s[0];
			card_prev_ff <= pin_s[1];
			card_ok_ff   <= pin_s[1] & pin_s[2];
		end
	end

	// decoded conditions
	assign in_init    = (state_ff == opmode_pkg::ST_LAMP_TEST) || (state_ff == opmode_pkg::ST_SYS_INIT);
	assign sel_up     = pin_s[0] & ~sel_prev_ff;
	assign card_take  = (pin_s[1] ^ card_prev_ff) & ~in_init;
	assign start_ok   = blocks_consistent & hw_config_loaded & card_ok_ff;
	assign auto_run   = (cfg_ff[1:0] == opmode_pkg::START_WARM_RUN) ||
	                    ((cfg_ff[1:0] == opmode_pkg::START_RESTORE) && prev_mode_run);
	assign run_req    = (cmd_ff[opmode_pkg::CMD_PG_RUN] | cmd_ff[opmode_pkg::CMD_DISP_RUN]) & pin_s[0];
	assign io_timeout = (io_cnt_ff >= IO_READY - 33'h1);

	// mode transitions
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			opmode_pkg::ST_LAMP_TEST:
				if (blink.tick && half_cnt_ff == opmode_pkg::LAMP_TEST_HALVES - 4'h1)
					nxt_state = opmode_pkg::ST_SYS_INIT;
			opmode_pkg::ST_SYS_INIT:
				if (card_eval_done)
				begin
					if (cfg_ff[opmode_pkg::CFG_COMMISSIONED] && start_ok && auto_run)
						nxt_state = opmode_pkg::ST_STARTUP;
					else
						nxt_state = opmode_pkg::ST_STOP;
				end
			opmode_pkg::ST_CARD_EVAL:
				if (card_eval_done)
					nxt_state = opmode_pkg::ST_STOP;
			opmode_pkg::ST_STOP:
				if (start_ok && (run_req || sel_up))
					nxt_state = opmode_pkg::ST_STARTUP;
			opmode_pkg::ST_STARTUP:
				if (startup_error || startup_stop_cmd || cmd_ff[opmode_pkg::CMD_PG_STOP])
					nxt_state = opmode_pkg::ST_STOP;
				else if (tags_initialized && startup_blocks_done && io_ready)
					nxt_state = opmode_pkg::ST_RUN;
				else if (io_timeout)
					nxt_state = opmode_pkg::ST_STOP;
			opmode_pkg::ST_RUN:
				if (run_error || user_stop_cmd || cmd_ff[opmode_pkg::CMD_PG_STOP] ||
				    cmd_ff[opmode_pkg::CMD_DISP_STOP] || !pin_s[0])
					nxt_state = opmode_pkg::ST_STOP;
			default:
				nxt_state = opmode_pkg::ST_STOP;
		endcase
		if (card_take)
			nxt_state = opmode_pkg::ST_CARD_EVAL;
	end

	// encoded mode register
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			state_ff <= opmode_pkg::ST_LAMP_TEST;
		else
			state_ff <= nxt_state;
	end

	// lamp test length and I/O readiness timers
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			half_cnt_ff <= 4'h0;
			io_cnt_ff   <= 33'h0;
		end
		else
		begin
			if (state_ff == opmode_pkg::ST_LAMP_TEST && blink.tick)
				half_cnt_ff <= half_cnt_ff + 4'h1;
			if (state_ff == opmode_pkg::ST_STARTUP && !io_timeout)
				io_cnt_ff <= io_cnt_ff + 33'h1;
			else if (state_ff != opmode_pkg::ST_STARTUP)
				io_cnt_ff <= 33'h0;
		end
	end

	// memory reset and non-retentive clear pulses
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mem_reset          <= 1'b0;
			clear_nonretentive <= 1'b0;
		end
		else
		begin
			mem_reset          <= card_take;
			clear_nonretentive <= ((state_ff == opmode_pkg::ST_SYS_INIT) &&
			                       (nxt_state == opmode_pkg::ST_STOP || nxt_state == opmode_pkg::ST_STARTUP)) ||
			                      ((state_ff == opmode_pkg::ST_STOP) &&
			                       (nxt_state == opmode_pkg::ST_STARTUP));
		end
	end

	// lamps, reported mode and network port follow the state
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mode_lamp_yellow    <= 1'b0;
			mode_lamp_green     <= 1'b0;
			fault_lamp          <= 1'b0;
			service_lamp        <= 1'b0;
			op_mode             <= opmode_pkg::MODE_INIT;
			network_port_enable <= 1'b0;
		end
		else
		begin
			fault_lamp          <= 1'b0;
			service_lamp        <= 1'b0;
			mode_lamp_yellow    <= 1'b0;
			mode_lamp_green     <= 1'b0;
			op_mode             <= opmode_pkg::MODE_INIT;
			network_port_enable <= 1'b1;
			unique case (state_ff)
				opmode_pkg::ST_LAMP_TEST:
				begin
					mode_lamp_yellow    <= blink.phase;
					mode_lamp_green     <= ~blink.phase;
					fault_lamp          <= blink.phase;
					service_lamp        <= blink.phase;
					network_port_enable <= 1'b0;
				end
				opmode_pkg::ST_SYS_INIT:
				begin
					mode_lamp_yellow    <= blink.phase;
					network_port_enable <= 1'b0;
				end
				opmode_pkg::ST_CARD_EVAL:
					mode_lamp_yellow <= blink.phase;
				opmode_pkg::ST_STOP:
				begin
					mode_lamp_yellow <= 1'b1;
					op_mode          <= opmode_pkg::MODE_STOP;
				end
				opmode_pkg::ST_STARTUP:
				begin
					mode_lamp_green <= blink.phase;
					op_mode         <= opmode_pkg::MODE_STARTUP;
				end
				opmode_pkg::ST_RUN:
				begin
					mode_lamp_green <= 1'b1;
					op_mode         <= opmode_pkg::MODE_RUN;
				end
				default:
					mode_lamp_yellow <= 1'b1;
			endcase
		end
	end

	// command pulses and configuration writes
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cmd_ff      <= 4'h0;
			cfg_ff      <= opmode_pkg::CFG_RESET;
			irq_mask_ff <= opmode_pkg::IRQ_RESET;
		end
		else
		begin
			cmd_ff <= (reg_wr && hit(reg_addr, opmode_pkg::OFS_CMD)) ? reg_wdata[3:0] : 4'h0;
			if (reg_wr && hit(reg_addr, opmode_pkg::OFS_CFG))
				cfg_ff <= reg_wdata[2:0];
			if (reg_wr && hit(reg_addr, opmode_pkg::OFS_IRQ_MASK))
				irq_mask_ff <= reg_wdata[opmode_pkg::IRQ_W-1:0];
		end
	end

	// interrupt events, write-one-to-clear where a new event wins
	always_comb
	begin
		event_v = '0;
		event_v[opmode_pkg::EV_STOP]       = (nxt_state == opmode_pkg::ST_STOP) && (state_ff != opmode_pkg::ST_STOP);
		event_v[opmode_pkg::EV_RUN]        = (nxt_state == opmode_pkg::ST_RUN) && (state_ff != opmode_pkg::ST_RUN);
		event_v[opmode_pkg::EV_ABORT]      = (state_ff == opmode_pkg::ST_STARTUP) &&
		                                     (nxt_state == opmode_pkg::ST_STOP);
		event_v[opmode_pkg::EV_CARD]       = card_take;
		event_v[opmode_pkg::EV_IO_TIMEOUT] = (state_ff == opmode_pkg::ST_STARTUP) && io_timeout && !io_ready;
		nxt_irq_stat = irq_stat_ff;
		if (reg_wr && hit(reg_addr, opmode_pkg::OFS_IRQ_STAT))
			nxt_irq_stat = irq_stat_ff & ~reg_wdata[opmode_pkg::IRQ_W-1:0];
		nxt_irq_stat = nxt_irq_stat | event_v;
	end

	// sticky status and level interrupt
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			irq_stat_ff <= opmode_pkg::IRQ_RESET;
			irq         <= 1'b0;
		end
		else
		begin
			irq_stat_ff <= nxt_irq_stat;
			irq         <= |(nxt_irq_stat & irq_mask_ff);
		end
	end

	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			reg_rdata <= 32'h0;
		else if (!reg_rd)
			reg_rdata <= 32'h0;
		else if (hit(reg_addr, opmode_pkg::OFS_CFG))
			reg_rdata <= {29'h0, cfg_ff};
		else if (hit(reg_addr, opmode_pkg::OFS_STATUS))
			reg_rdata <= {24'h0, card_ok_ff, pin_s[0], op_mode, 1'b0, state_ff};
		else if (hit(reg_addr, opmode_pkg::OFS_IRQ_STAT))
			reg_rdata <= {27'h0, irq_stat_ff};
		else if (hit(reg_addr, opmode_pkg::OFS_IRQ_MASK))
			reg_rdata <= {27'h0, irq_mask_ff};
		else
			reg_rdata <= 32'h0;
	end

	chk_card_reset:
	assert property (@(posedge core_clk) disable iff (!resetn)
		card_take |=> mem_reset && state_ff == opmode_pkg::ST_CARD_EVAL)
		else $error("card event did not reset memory");

	chk_eval_flash:
	assert property (@(posedge core_clk) disable iff (!resetn)
		state_ff == opmode_pkg::ST_CARD_EVAL |=> !mode_lamp_green && mode_lamp_yellow == $past(blink.phase))
		else $error("mode lamp not flashing during card evaluation");

	chk_card_format:
	assert property (@(posedge core_clk) disable iff (!resetn)
		state_ff == opmode_pkg::ST_STOP && !card_ok_ff && !card_take |=> state_ff == opmode_pkg::ST_STOP)
		else $error("started without a formatted card");

	chk_lamp_test:
	assert property (@(posedge core_clk) disable iff (!resetn)
		resetn && $past(resetn) && state_ff == opmode_pkg::ST_LAMP_TEST |=>
		mode_lamp_green == !mode_lamp_yellow && fault_lamp == mode_lamp_yellow && service_lamp == mode_lamp_yellow)
		else $error("lamp test pattern wrong");

	chk_first_stop:
	assert property (@(posedge core_clk) disable iff (!resetn)
		state_ff == opmode_pkg::ST_SYS_INIT && card_eval_done && !cfg_ff[opmode_pkg::CFG_COMMISSIONED] |=>
		state_ff == opmode_pkg::ST_STOP ##1 mode_lamp_yellow && !mode_lamp_green)
		else $error("first power-on did not settle in STOP");

	chk_net_port:
	assert property (@(posedge core_clk) disable iff (!resetn)
		!in_init |=> network_port_enable)
		else $error("network port disabled in an operating mode");

	chk_no_restart:
	assert property (@(posedge core_clk) disable iff (!resetn)
		state_ff == opmode_pkg::ST_SYS_INIT && card_eval_done &&
		cfg_ff[1:0] == opmode_pkg::START_NO_RESTART |=> state_ff == opmode_pkg::ST_STOP)
		else $error("no-restart type did not power on into STOP");

	chk_clear_pulse:
	assert property (@(posedge core_clk) disable iff (!resetn)
		state_ff == opmode_pkg::ST_STOP && nxt_state == opmode_pkg::ST_STARTUP |=> clear_nonretentive)
		else $error("non-retentive clear missing on STOP to STARTUP");

	chk_startup_abort:
	assert property (@(posedge core_clk) disable iff (!resetn)
		state_ff == opmode_pkg::ST_STARTUP && (startup_error || startup_stop_cmd) && !card_take |=>
		state_ff == opmode_pkg::ST_STOP ##1 op_mode == opmode_pkg::MODE_STOP)
		else $error("startup not cancelled");

	chk_run_stop:
	assert property (@(posedge core_clk) disable iff (!resetn)
		state_ff == opmode_pkg::ST_RUN && (run_error || user_stop_cmd) && !card_take |=>
		state_ff == opmode_pkg::ST_STOP)
		else $error("RUN did not stop");

	chk_io_window:
	assert property (@(posedge core_clk) disable iff (!resetn)
		$rose(state_ff == opmode_pkg::ST_RUN) |-> io_ready || $past(io_ready))
		else $error("RUN entered without I/O ready");

endmodule // opmode_seq

// ---- sim/opmode_far_side.sv ----
// far-side model: mode selector and removable memory card
`timescale 1ns/10ps
module opmode_far_side
(
	input  wire logic core_clk,
	output logic      selector_run,
	output logic      card_present,
	output logic      card_formatted,
	output logic      card_eval_done
);
	logic sel_v  = 1'b1;
	logic pres_v = 1'b1;
	logic fmt_v  = 1'b1;
	logic eval_v = 1'b0;
	initial
	begin
		selector_run = 1'b1;
		card_present = 1'b1;
		card_formatted = 1'b1;
		card_eval_done = 1'b0;
	end
	// pins follow the requests; formatted line wanders while the slot is empty
	always @(posedge core_clk)
	begin
		selector_run <= sel_v;
		card_present <= pres_v;
		card_formatted <= pres_v ? fmt_v : ~card_formatted;
		card_eval_done <= eval_v;
		eval_v = 1'b0;
	end
	// requests land at the falling edge, picked up at the next rising edge
	task automatic set_sel(input logic v);
		@(negedge core_clk);
		sel_v = v;
	endtask
	task automatic put_card(input logic p, input logic f);
		@(negedge core_clk);
		pres_v = p;
		fmt_v = f;
	endtask
	// evaluation ends after a random 1..8 cycles
	task automatic finish_eval();
		repeat ($urandom_range(8, 1)) @(posedge core_clk);
		@(negedge core_clk);
		eval_v = 1'b1;
	endtask
endmodule // opmode_far_side

// ---- sim/controller_operating_mode_fsm_tb_top.sv ----
// self-checking bench of the operating-mode sequencer
`timescale 1ns/10ps
module controller_operating_mode_fsm_tb_top;
	logic        core_clk;
	logic        resetn;
	logic [4:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        selector_run, card_present, card_formatted, card_eval_done;
	logic        hw_config_loaded, blocks_consistent, prev_mode_run;
	logic        startup_error, startup_stop_cmd, tags_initialized;
	logic        startup_blocks_done, io_ready, run_error, user_stop_cmd;
	logic        mode_lamp_yellow, mode_lamp_green, fault_lamp, service_lamp;
	logic        mem_reset, clear_nonretentive, network_port_enable, irq;
	logic [1:0]  op_mode;
	logic        rd_q = 1'b0;
	int          fail_count = 0;
	int          n_compared = 0;
	int          n_mem = 0;
	int          n_clr = 0;
	logic [31:0] exp_q[$];
	logic [31:0] msk_q[$];
	logic [2:0]  pc_cfg[5] = '{3'h5, 3'h6, 3'h6, 3'h4, 3'h5};
	logic        pc_prev[5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
	logic        pc_blk[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	logic [1:0]  pc_exp[5] = '{2'h1, 2'h1, 2'h0, 2'h0, 2'h0};

	opmode_far_side far (.core_clk(core_clk), .selector_run(selector_run), .card_present(card_present),
		.card_formatted(card_formatted), .card_eval_done(card_eval_done));

	opmode_seq #(.BLINK_HALF(32'h4), .IO_READY(33'h32)) DUT
	(
		.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .selector_run(selector_run),
		.card_present(card_present), .card_formatted(card_formatted), .card_eval_done(card_eval_done),
		.hw_config_loaded(hw_config_loaded), .blocks_consistent(blocks_consistent),
		.prev_mode_run(prev_mode_run), .startup_error(startup_error), .startup_stop_cmd(startup_stop_cmd),
		.tags_initialized(tags_initialized), .startup_blocks_done(startup_blocks_done), .io_ready(io_ready),
		.run_error(run_error), .user_stop_cmd(user_stop_cmd), .mode_lamp_yellow(mode_lamp_yellow),
		.mode_lamp_green(mode_lamp_green), .fault_lamp(fault_lamp), .service_lamp(service_lamp),
		.mem_reset(mem_reset), .clear_nonretentive(clear_nonretentive),
		.network_port_enable(network_port_enable), .op_mode(op_mode), .irq(irq)
	);

	// 100 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic do_reset();
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	// read: note expected value and mask for the watcher
	task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		exp_q.push_back(e);
		msk_q.push_back(m);
		@(posedge core_clk);
		reg_rd <= 1'b0;
	endtask

	task automatic wait_mode(input logic [1:0] e);
		int k;
		k = 0;
		while (op_mode !== e && k < 300)
		begin
			@(negedge core_clk);
			k++;
		end
		check("op_mode", 32'(op_mode), 32'(e));
	endtask

	// lamp on-counts over 16 cycles, two blink periods
	task automatic lamps(input int ey, input int eg, input int ef, input int es);
		int y, g, f, s, b;
		y = 0;
		g = 0;
		f = 0;
		s = 0;
		b = 0;
		repeat (16)
		begin
			@(negedge core_clk);
			y += mode_lamp_yellow;
			g += mode_lamp_green;
			f += fault_lamp;
			s += service_lamp;
			b += mode_lamp_yellow & mode_lamp_green;
		end
		check("yellow", 32'(y), 32'(ey));
		check("green", 32'(g), 32'(eg));
		check("fault", 32'(f), 32'(ef));
		check("service", 32'(s), 32'(es));
		check("both", 32'(b), 32'h0);
	endtask

	// watcher: read data in the cycle after the strobe, pulse counts
	always @(posedge core_clk)
		rd_q <= reg_rd;
	always @(negedge core_clk)
	begin
		if (mem_reset === 1'b1)
			n_mem++;
		if (clear_nonretentive === 1'b1)
			n_clr++;
		if (rd_q && exp_q.size() > 0)
			check("reg_rdata", reg_rdata & msk_q.pop_front(), exp_q.pop_front());
	end

	// watchdog
	initial
	begin
		repeat (20000) @(posedge core_clk);
		fail_count++;
		test_done();
	end

	// main sequence
	initial
	begin
		resetn = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		hw_config_loaded = 1'b1;
		blocks_consistent = 1'b1;
		prev_mode_run = 1'b0;
		startup_error = 1'b0;
		startup_stop_cmd = 1'b0;
		tags_initialized = 1'b0;
		startup_blocks_done = 1'b0;
		io_ready = 1'b0;
		run_error = 1'b0;
		user_stop_cmd = 1'b0;
		void'($urandom(86));
		do_reset();
		@(negedge core_clk);
		check("op_mode", 32'(op_mode), 32'(opmode_pkg::MODE_INIT));
		check("pulses", 32'({mem_reset, clear_nonretentive, irq}), 32'h0);
		cyc(3);
		lamps(8, 8, 8, 8);
		wr(5'h14, $urandom());
		rd(5'h14, 32'h0, 32'hFFFFFFFF);
		rd(opmode_pkg::OFS_CFG, 32'h0, 32'hFFFFFFFF);
		rd(opmode_pkg::OFS_IRQ_MASK, 32'h0, 32'hFFFFFFFF);
		cyc(10);
		lamps(8, 0, 0, 0);
		far.finish_eval();
		wait_mode(opmode_pkg::MODE_STOP);
		lamps(16, 0, 0, 0);
		check("net", 32'(network_port_enable), 32'h1);
		check("clr", 32'(n_clr), 32'h1);
		check("irq", 32'(irq), 32'h0);
		rd(opmode_pkg::OFS_STATUS, 32'hC2, 32'hFFFFFFFF);
		wr(opmode_pkg::OFS_IRQ_MASK, 32'h1F);
		wr(opmode_pkg::OFS_IRQ_STAT, 32'h1F);
		// start refused without hardware configuration
		@(posedge core_clk);
		hw_config_loaded <= 1'b0;
		wr(opmode_pkg::OFS_CMD, 32'h1);
		cyc(10);
		check("op_mode", 32'(op_mode), 32'(opmode_pkg::MODE_STOP));
		@(posedge core_clk);
		hw_config_loaded <= 1'b1;
		wr(opmode_pkg::OFS_CMD, 32'h1);
		wait_mode(opmode_pkg::MODE_STARTUP);
		check("clr", 32'(n_clr), 32'h2);
		lamps(0, 8, 0, 0);
		// I/O never ready: timeout back to STOP
		@(posedge core_clk);
		tags_initialized <= 1'b1;
		startup_blocks_done <= 1'b1;
		cyc(20);
		check("op_mode", 32'(op_mode), 32'(opmode_pkg::MODE_STARTUP));
		wait_mode(opmode_pkg::MODE_STOP);
		rd(opmode_pkg::OFS_IRQ_STAT, 32'h10, 32'h10);
		check("irq", 32'(irq), 32'h1);
		wr(opmode_pkg::OFS_IRQ_STAT, 32'h1F);
		cyc(2);
		check("irq", 32'(irq), 32'h0);
		// selector STOP to RUN, then tags_initialized gates RUN
		@(posedge core_clk);
		io_ready <= 1'b1;
		tags_initialized <= 1'b0;
		far.set_sel(1'b0);
		cyc(6);
		far.set_sel(1'b1);
		wait_mode(opmode_pkg::MODE_STARTUP);
		cyc(10);
		check("op_mode", 32'(op_mode), 32'(opmode_pkg::MODE_STARTUP));
		@(posedge core_clk);
		tags_initialized <= 1'b1;
		wait_mode(opmode_pkg::MODE_RUN);
		lamps(0, 16, 0, 0);
		rd(opmode_pkg::OFS_IRQ_STAT, 32'h2, 32'h2);
		// every stop cause in RUN
		for (int i = 0; i < 5; i++)
		begin
			@(posedge core_clk);
			run_error <= (i == 0);
			user_stop_cmd <= (i == 1);
			if (i == 2 || i == 3)
				wr(opmode_pkg::OFS_CMD, (i == 2) ? 32'h4 : 32'h8);
			if (i == 4)
				far.set_sel(1'b0);
			wait_mode(opmode_pkg::MODE_STOP);
			@(posedge core_clk);
			run_error <= 1'b0;
			user_stop_cmd <= 1'b0;
			if (i < 4)
			begin
				wr(opmode_pkg::OFS_CMD, 32'h2);
				wait_mode(opmode_pkg::MODE_RUN);
			end
		end
		wr(opmode_pkg::OFS_CMD, 32'h1);
		cyc(10);
		check("op_mode", 32'(op_mode), 32'(opmode_pkg::MODE_STOP));
		// every stop cause in STARTUP but the I/O timeout
		@(posedge core_clk);
		startup_blocks_done <= 1'b0;
		for (int i = 0; i < 3; i++)
		begin
			if (i == 0)
				far.set_sel(1'b1);
			else
				wr(opmode_pkg::OFS_CMD, 32'h1);
			wait_mode(opmode_pkg::MODE_STARTUP);
			@(posedge core_clk);
			startup_error <= (i == 0);
			startup_stop_cmd <= (i == 1);
			if (i == 2)
				wr(opmode_pkg::OFS_CMD, 32'h4);
			wait_mode(opmode_pkg::MODE_STOP);
			@(posedge core_clk);
			startup_error <= 1'b0;
			startup_stop_cmd <= 1'b0;
			rd(opmode_pkg::OFS_IRQ_STAT, 32'h4, 32'h4);
			wr(opmode_pkg::OFS_IRQ_STAT, 32'h1F);
		end
		// card removed, unformatted card, removed again, formatted card
		n_mem = 0;
		for (int i = 0; i < 4; i++)
		begin
			far.put_card(i % 2 == 1, i == 3);
			cyc(8);
			check("mem_reset", 32'(n_mem), 32'(i + 1));
			check("op_mode", 32'(op_mode), 32'(opmode_pkg::MODE_INIT));
			lamps(8, 0, 0, 0);
			far.finish_eval();
			wait_mode(opmode_pkg::MODE_STOP);
			rd(opmode_pkg::OFS_STATUS, (i == 3) ? 32'h80 : 32'h0, 32'h80);
			if (i < 3)
			begin
				wr(opmode_pkg::OFS_CMD, 32'h1);
				cyc(10);
				check("op_mode", 32'(op_mode), 32'(opmode_pkg::MODE_STOP));
			end
		end
		// power-on startup types after a reset in STOP or STARTUP
		for (int i = 0; i < 5; i++)
		begin
			n_clr = 0;
			@(posedge core_clk);
			prev_mode_run <= pc_prev[i];
			blocks_consistent <= pc_blk[i];
			// random levels, harmless while startup blocks stay unfinished
			tags_initialized <= 1'($urandom());
			io_ready <= 1'($urandom());
			run_error <= 1'($urandom());
			user_stop_cmd <= 1'($urandom());
			do_reset();
			wr(opmode_pkg::OFS_CFG, 32'(pc_cfg[i]));
			cyc(40);
			far.finish_eval();
			wait_mode(pc_exp[i]);
			cyc(4);
			check("clr", 32'(n_clr), 32'h1);
		end
		test_done();
	end
endmodule // controller_operating_mode_fsm_tb_top
